// ### logic/fkt_map.svh
`ifndef FKT_MAP_SVH
`define FKT_MAP_SVH

`define FKT_CODE_W    5
`define FKT_ROW_W     2
`define FKT_TICK_W    16
`define FKT_IDX_W     3
`define FKT_CODE_RST  5'h00
`define FKT_ELEM_LAST 3'h4
`define FKT_IDX_FIRST 3'h0
`define FKT_IDX_STEP  3'h1
`define FKT_ROW_THIRD 2'h2
`define FKT_ROW_FOURTH 2'h3
`define FKT_TICK_ZERO 16'h0000
`define FKT_TICK_ONE  16'h0001

`endif

// ### logic/fkt_pkg.sv
`include "fkt_map.svh"

package fkt_pkg;

    typedef enum logic [1:0] {
        FKT_IDLE  = 2'b00,
        FKT_START = 2'b01,
        FKT_DATA  = 2'b10,
        FKT_STOP  = 2'b11
    } fkt_state_type;

    typedef struct packed {
        logic                     pressed;
        logic [`FKT_ROW_W-1:0]    row;
        logic [`FKT_CODE_W-1:0]   code;
    } fkt_key_type;

    typedef struct packed {
        logic breakKey;
        logic holdRetransmitKey;
        logic answerbackTriggerKey;
    } fkt_func_keys_type;

endpackage

// ### logic/fkt_keyboard_tx.sv
`timescale 1ns/1ns
`include "fkt_map.svh"

module fkt_keyboard_tx
    import fkt_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire fkt_key_type              charKey,
    input  wire fkt_func_keys_type        funcKeys,
    input  wire logic                     fourRowKeyboard,
    input  wire logic                     figuresCondition,
    input  wire logic [`FKT_TICK_W-1:0]   elementTicks,
    output logic                          lineMark_q,
    output logic [`FKT_CODE_W-1:0]        codeReg_q,
    output logic [`FKT_CODE_W-1:0]        contacts_q,
    output logic                          busy_q,
    output logic                          answerbackStart_q
);

    fkt_state_type               state_q;
    fkt_state_type               state_d;
    logic [`FKT_IDX_W-1:0]       bitIdx_q;
    logic [`FKT_TICK_W-1:0]      tickCnt_q;
    logic                        armed_q;
    logic                        answerbackKey_q;
    logic                        tick;
    logic                        rowBlocked;
    logic                        capture;
    logic                        repeatNow;

    // A zero setting would wrap the divider's last count to 16'hFFFF, so it acts as one cycle
    function automatic logic [`FKT_TICK_W-1:0] last_tick(
        input logic [`FKT_TICK_W-1:0] ticks
    );
        logic [`FKT_TICK_W-1:0] lim;
        lim = (ticks == `FKT_TICK_ZERO) ? `FKT_TICK_ONE : ticks;
        return lim - `FKT_TICK_ONE;
    endfunction

    function automatic logic is_blocked(
        input logic                  fourRow,
        input logic                  figures,
        input logic [`FKT_ROW_W-1:0] row
    );
        return fourRow && ((figures && row == `FKT_ROW_THIRD) ||
                           (!figures && row == `FKT_ROW_FOURTH));
    endfunction

    assign tick       = (state_q != FKT_IDLE) && (tickCnt_q == last_tick(elementTicks));
    assign rowBlocked = is_blocked(fourRowKeyboard, figuresCondition, charKey.row);
    // Keys are only captured while idle and armed; a held key owns the mechanism
    assign capture    = (state_q == FKT_IDLE) && armed_q && charKey.pressed
                        && !rowBlocked;
    assign repeatNow  = charKey.pressed && funcKeys.holdRetransmitKey
                        && !rowBlocked;

    always_comb begin
        state_d = state_q;
        case (state_q)
            FKT_IDLE: begin
                if (capture) begin
                    state_d = FKT_START;
                end
            end
            FKT_START: begin
                if (tick) begin
                    state_d = FKT_DATA;
                end
            end
            FKT_DATA: begin
                if (tick && bitIdx_q == `FKT_ELEM_LAST) begin
                    state_d = FKT_STOP;
                end
            end
            FKT_STOP: begin
                if (tick) begin
                    state_d = repeatNow ? FKT_START : FKT_IDLE;
                end
            end
            default: begin
                state_d = FKT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= FKT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Element divider restarts with each element so every element is a full interval
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_q <= `FKT_TICK_ZERO;
        end else if (state_q == FKT_IDLE || tick) begin
            tickCnt_q <= `FKT_TICK_ZERO;
        end else begin
            tickCnt_q <= tickCnt_q + `FKT_TICK_ONE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bitIdx_q <= `FKT_IDX_FIRST;
        end else if (state_q == FKT_START) begin
            bitIdx_q <= `FKT_IDX_FIRST;
        end else if (state_q == FKT_DATA && tick) begin
            bitIdx_q <= bitIdx_q + `FKT_IDX_STEP;
        end
    end

    // Only differing elements toggle; the rest keep their state across presses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            codeReg_q <= `FKT_CODE_RST;
        end else if (capture) begin
            codeReg_q <= codeReg_q ^ (codeReg_q ^ charKey.code);
        end
    end

    // Trip latch: a held key may not retrip the cycle, unless retransmit holds it open
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_q <= 1'b1;
        end else if (capture) begin
            armed_q <= 1'b0;
        end else if (state_q == FKT_STOP || state_q == FKT_IDLE) begin
            armed_q <= !charKey.pressed;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            contacts_q <= `FKT_CODE_RST;
        end else if (state_q == FKT_START || state_q == FKT_DATA) begin
            contacts_q <= codeReg_q;
        end else begin
            contacts_q <= `FKT_CODE_RST;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineMark_q <= 1'b1;
        end else if (funcKeys.breakKey) begin
            lineMark_q <= 1'b0;
        end else begin
            case (state_q)
                FKT_START: lineMark_q <= 1'b0;
                FKT_DATA:  lineMark_q <= codeReg_q[bitIdx_q];
                default:   lineMark_q <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d != FKT_IDLE);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            answerbackKey_q   <= 1'b0;
            answerbackStart_q <= 1'b0;
        end else begin
            answerbackKey_q   <= funcKeys.answerbackTriggerKey;
            answerbackStart_q <= funcKeys.answerbackTriggerKey && !answerbackKey_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence idle_no_break_s;
        state_q == FKT_IDLE && !funcKeys.breakKey;
    endsequence

    sequence last_elem_done_s;
        state_q == FKT_DATA && tick && bitIdx_q == `FKT_ELEM_LAST;
    endsequence

    sequence stop_end_s;
        state_q == FKT_STOP && tick;
    endsequence

    idle_line_mark_a: assert property (
        idle_no_break_s |=> lineMark_q)
        else $error("line not marking while idle");

    break_holds_space_a: assert property (
        funcKeys.breakKey |=> !lineMark_q)
        else $error("line not spacing during break");

    start_elem_space_a: assert property (
        state_q == FKT_START && !funcKeys.breakKey |=> !lineMark_q)
        else $error("start element not spacing");

    data_elem_value_a: assert property (
        state_q == FKT_DATA && !funcKeys.breakKey
        |=> lineMark_q == $past(codeReg_q[bitIdx_q]))
        else $error("code element does not match contact");

    code_frozen_a: assert property (
        state_q != FKT_IDLE |=> $stable(codeReg_q))
        else $error("code register changed during cycle");

    stop_after_five_a: assert property (
        last_elem_done_s |=> state_q == FKT_STOP ##1 (lineMark_q || $past(funcKeys.breakKey)))
        else $error("no stop after element five");

    no_retrip_held_a: assert property (
        stop_end_s and ##0 (charKey.pressed && !funcKeys.holdRetransmitKey)
        |=> state_q == FKT_IDLE ##1 state_q == FKT_IDLE)
        else $error("held key retripped the cycle");

    repeat_restart_a: assert property (
        stop_end_s and ##0 repeatNow |=> state_q == FKT_START)
        else $error("retransmit did not restart");

    contacts_open_a: assert property (
        state_q == FKT_STOP |=> contacts_q == `FKT_CODE_RST)
        else $error("contacts not open at cycle end");

    row_block_a: assert property (
        state_q == FKT_IDLE && rowBlocked |=> state_q == FKT_IDLE)
        else $error("blocked row started a cycle");

    start_one_elem_a: assert property (
        state_q == FKT_START && tick |=> state_q == FKT_DATA && bitIdx_q == `FKT_IDX_FIRST)
        else $error("start element length wrong");

    answerback_pulse_a: assert property (
        $rose(funcKeys.answerbackTriggerKey) |=> answerbackStart_q ##1 !answerbackStart_q)
        else $error("answerback start missing");

    single_capture_a: assert property (
        state_q == FKT_START |-> !armed_q)
        else $error("trip latch armed during cycle");

endmodule

// ### dv/fkt_remote_rx.sv
`timescale 1ns/1ns

module fkt_remote_rx (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        line,
    input  wire logic [15:0] ticks,
    output logic [4:0]       rxCode_q,
    output logic             rxValid_q
);
    logic [15:0] cnt_q;
    logic [2:0]  idx_q;
    logic        act_q;
    logic        armed_q;

    // Samples mid-element, one and a half elements after the start edge, so a slow edge never lands on the sample point
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q     <= 16'h0000;
            idx_q     <= 3'h0;
            act_q     <= 1'b0;
            armed_q   <= 1'b0;
            rxCode_q  <= 5'h00;
            rxValid_q <= 1'b0;
        end else begin
            rxValid_q <= 1'b0;
            if (!act_q) begin
                if (line) begin
                    armed_q <= 1'b1;
                end else if (armed_q) begin
                    act_q <= 1'b1;
                    idx_q <= 3'h0;
                    cnt_q <= ticks + (ticks >> 1) - 16'h0001;
                end
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end else begin
                rxCode_q[idx_q] <= line;
                cnt_q <= ticks - 16'h0001;
                idx_q <= idx_q + 3'h1;
                if (idx_q == 3'h4) begin
                    act_q     <= 1'b0;
                    armed_q   <= 1'b0; // Wait for the stop mark before the next start
                    rxValid_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ### dv/fkt_keyboard_tx_tb.sv
`timescale 1ns/1ns
`include "fkt_map.svh"

module fkt_keyboard_tx_tb;
    import fkt_pkg::*;
    logic                   clk, reset_n, fourRow, figures, lineMark, busy, abStart, rxValid;
    fkt_key_type            charKey;
    fkt_func_keys_type      funcKeys;
    logic [`FKT_TICK_W-1:0] ticks;
    logic [`FKT_CODE_W-1:0] codeReg, contacts, rxCode;
    logic [4:0]             expQ[$];
    logic [31:0]            lfsr;
    int                     errCount, cmpCount;

    fkt_keyboard_tx dut_u (.clk(clk), .reset_n(reset_n), .charKey(charKey),
        .funcKeys(funcKeys), .fourRowKeyboard(fourRow), .figuresCondition(figures),
        .elementTicks(ticks), .lineMark_q(lineMark), .codeReg_q(codeReg),
        .contacts_q(contacts), .busy_q(busy), .answerbackStart_q(abStart));
    fkt_remote_rx rx_u (.clk(clk), .reset_n(reset_n), .line(lineMark), .ticks(ticks),
        .rxCode_q(rxCode), .rxValid_q(rxValid));

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic waitBusy(input logic v);
        int i;
        i = 0;
        while (busy !== v && i < 200) begin
            @(posedge clk);
            #1;
            i++;
        end
        check(busy, v);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Press, try a second key mid-cycle, release, then look at the held code
    task automatic sendChar(input logic [4:0] code, input logic [1:0] row);
        @(posedge clk);
        charKey <= '{1'b1, row, code};
        expQ.push_back(code);
        waitBusy(1'b1);
        idle(1);
        check(contacts, code);
        charKey.code <= ~code;
        idle(1);
        charKey.pressed <= 1'b0;
        waitBusy(1'b0);
        check(codeReg, code);
        check(lineMark, 1'b1);
        check(contacts, 5'h00);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Compares each received character against the oldest note
    always @(posedge clk) begin
        if (rxValid === 1'b1) begin
            if (expQ.size() == 0) check(rxValid, 1'b0);
            else check(rxCode, expQ.pop_front());
        end
    end
    initial begin
        #120000;
        errCount++;
        summarize();
    end

    initial begin
        int i;
        reset_n = 1'b0;
        charKey = '0;
        funcKeys = '0;
        fourRow = 1'b0;
        figures = 1'b0;
        ticks = 16'h0002;
        lfsr = 32'h043ca2d7;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        idle(2);
        check(lineMark, 1'b1);
        sendChar(5'h09, 2'h0);
        for (i = 0; i < 8; i++) begin
            lfsr = lfsrNext(lfsr);
            sendChar(lfsr[4:0], lfsr[6:5]);
        end
        ticks <= 16'h0001;
        sendChar(5'h12, 2'h1);
        ticks <= 16'h0003;
        sendChar(5'h0d, 2'h0);
        ticks <= 16'h0002;
        $display("test basic done");
        @(posedge clk);
        charKey <= '{1'b1, 2'h0, 5'h15};
        expQ.push_back(5'h15);
        waitBusy(1'b1);
        waitBusy(1'b0);
        idle(40);
        check(busy, 1'b0);
        charKey.pressed <= 1'b0;
        idle(2);
        $display("test held done");
        @(posedge clk);
        charKey <= '{1'b1, 2'h1, 5'h1a};
        funcKeys.holdRetransmitKey <= 1'b1;
        expQ.push_back(5'h1a);
        expQ.push_back(5'h1a);
        i = 0;
        // Let go once the first copy is in, so exactly one more copy goes out
        while (expQ.size() > 1 && i < 500) begin
            idle(1);
            i++;
        end
        charKey.pressed <= 1'b0;
        funcKeys.holdRetransmitKey <= 1'b0;
        waitBusy(1'b0);
        check(expQ.size(), 0);
        $display("test repeat done");
        fourRow <= 1'b1;
        figures <= 1'b1;
        charKey <= '{1'b1, 2'h2, 5'h03};
        idle(6);
        check(busy, 1'b0);
        // Release first so the trip latch is armed again for the next try
        charKey.pressed <= 1'b0;
        idle(2);
        figures <= 1'b0;
        charKey <= '{1'b1, 2'h3, 5'h03};
        idle(6);
        check(busy, 1'b0);
        charKey.pressed <= 1'b0;
        idle(2);
        figures <= 1'b1;
        sendChar(5'h07, 2'h3);
        $display("test rows done");
        @(posedge clk);
        funcKeys.breakKey <= 1'b1;
        expQ.push_back(5'h00);
        idle(3);
        check(lineMark, 1'b0);
        idle(20);
        check(lineMark, 1'b0);
        funcKeys.breakKey <= 1'b0;
        idle(3);
        check(lineMark, 1'b1);
        $display("test break done");
        @(posedge clk);
        funcKeys.answerbackTriggerKey <= 1'b1;
        @(posedge clk);
        #1;
        check(abStart, 1'b1);
        idle(1);
        check(abStart, 1'b0);
        funcKeys.answerbackTriggerKey <= 1'b0;
        idle(20);
        check(expQ.size(), 0);
        $display("test answerback done");
        summarize();
    end
endmodule
